// File: pcg_pkg.sv
package pcg_pkg;
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0]  OFS_CTRL1      = 4'h0;
  localparam logic [3:0]  OFS_CTRL2      = 4'h4;
  localparam logic [3:0]  OFS_TERM_LO    = 4'h8;
  localparam logic [3:0]  OFS_TERM_HI    = 4'hC;
  localparam int          ADDR_W         = 4;
  // The data port and the result port are separate windows at higher offsets.
  localparam logic [4:0]  OFS_DATA       = 5'h10;
  localparam logic [4:0]  OFS_RESULT     = 5'h14;
  localparam int          BUS_ADDR_W     = 5;
  // Control word one fields.
  localparam int          C1_START       = 0;
  localparam int          C1_LSB_FIRST   = 1;
  localparam int          C1_IRQ_EN      = 2;
  localparam int          C1_DONE        = 8;
  localparam int          C1_BUSY        = 9;
  localparam int          C1_FIFO_EMPTY  = 10;
  localparam int          C1_FIFO_FULL   = 11;
  // Control word two fields.
  localparam int          C2_PLEN_LSB    = 0;
  localparam int          C2_DWIDTH_LSB  = 8;
  localparam int          FIELD_W        = 5;
  localparam logic [4:0]  PLEN_RESET     = 5'h0F;
  localparam logic [4:0]  DWIDTH_RESET   = 5'h07;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          DATA_W         = 32;

  typedef enum logic [1:0] {PCG_IDLE, PCG_LOAD, PCG_SHIFT} pcg_state_e;
endpackage : pcg_pkg

// File: pcg_stream_if.sv
`timescale 1ns/1ps
interface pcg_stream_if #(parameter int W = 32);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : pcg_stream_if

// File: pcg_fifo.sv
`timescale 1ns/1ps
module pcg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Streams
  pcg_stream_if.snk in_s,
  pcg_stream_if.src out_s,
  // Status
  output logic     full,
  output logic     empty
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_r;
  logic [PW:0]      rd_r;
  wire              push = in_s.valid & in_s.ready;
  wire              pop  = out_s.valid & out_s.ready;

  assign empty       = (wr_r == rd_r);
  assign full        = (wr_r[PW] != rd_r[PW]) && (wr_r[PW-1:0] == rd_r[PW-1:0]);
  assign in_s.ready  = ~full;
  assign out_s.valid = ~empty;
  assign out_s.data  = mem[rd_r[PW-1:0]];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop)  rd_r <= rd_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_r[PW-1:0]] <= in_s.data;
  end

  property p_no_overfill;
    @(posedge clk) disable iff (reset)
      full |=> !(wr_r != $past(wr_r) && rd_r == $past(rd_r));
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("fifo pointer advanced while full");
endmodule : pcg_fifo

// File: pcg_crc_top.sv
`timescale 1ns/1ps
module pcg_crc_top (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  // Avalon-MM slave
  input  wire logic [pcg_pkg::BUS_ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  // Interrupt
  output logic                           crc_irq
);
  import pcg_pkg::*;

  pcg_stream_if #(.W(DATA_W)) fin ();
  pcg_stream_if #(.W(DATA_W)) fout ();
  logic fifo_full;
  logic fifo_empty;

  pcg_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (core_clk),
    .reset (reset),
    .in_s  (fin.snk),
    .out_s (fout.src),
    .full  (fifo_full),
    .empty (fifo_empty)
  );

  // Registers.
  logic        lsb_first_r;
  logic        irq_en_r;
  logic        done_r;
  logic [4:0]  plen_r;
  logic [4:0]  dwidth_r;
  logic [31:0] term_lo_r;
  logic [31:0] term_hi_r;
  logic [31:0] crc_r;
  logic [31:0] crc_nxt;
  logic [31:0] shreg_r;
  logic [4:0]  bitcnt_r;
  logic        ack_r;
  pcg_state_e  state_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // Each register occupies a 16-bit term word; low and high words form taps 0..31.
  wire [31:0] taps_raw = {term_hi_r[15:0], term_lo_r[15:0]};
  // Bit 0 is forced, and bit 31 of the term pair is bit x31, so x32 has no storage.
  wire [31:0] taps     = {taps_raw[31:1], 1'b1};
  // Polynomial order is the field plus one, so a field of 31 yields a 32-bit engine.
  wire [31:0] len_mask = (plen_r == 5'h1F) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (plen_r + 5'h01)) - 32'h0000_0001);
  wire [31:0] msb_sel  = 32'h0000_0001 << plen_r;

  // Selected input bit: LSB-first walks upward, MSB-first walks down from bit dwidth_r, the top data bit.
  wire        in_bit   = lsb_first_r ? shreg_r[bitcnt_r] : shreg_r[dwidth_r - bitcnt_r];
  // The top-order term is implicit: feedback is the engine's top bit XOR the input.
  wire        fb       = |(crc_r & msb_sel) ^ in_bit;

  always_comb begin
    crc_nxt = ((crc_r << 1) ^ ({32{fb}} & taps)) & len_mask;
  end

  // Bus decode.
  // Writes land at the edge where the master samples waitrequest low, so nothing moves before the transfer ends.
  wire        acc      = (avs_read | avs_write) & ~ack_r;
  wire        wr_c1    = avs_write & ack_r & (avs_address == {1'b0, OFS_CTRL1});
  wire        wr_c2    = avs_write & ack_r & (avs_address == {1'b0, OFS_CTRL2});
  wire        wr_lo    = avs_write & ack_r & (avs_address == {1'b0, OFS_TERM_LO});
  wire        wr_hi    = avs_write & ack_r & (avs_address == {1'b0, OFS_TERM_HI});
  wire        wr_res   = avs_write & ack_r & (avs_address == OFS_RESULT);
  wire        wr_dat   = avs_write & (avs_address == OFS_DATA);
  wire        dat_ok   = wr_dat & ack_r & fin.ready;
  wire        start    = wr_c1 & avs_writedata[C1_START];
  wire        busy     = (state_r != PCG_IDLE);
  wire        last_bit = (bitcnt_r == dwidth_r);
  // Done rises when the FIFO runs dry after a word; set wins over clear.
  wire        done_set = (state_r == PCG_SHIFT) & last_bit & ~fout.valid;

  assign fin.data  = avs_writedata;
  assign fin.valid = dat_ok;
  assign fout.ready = (state_r == PCG_LOAD);

  // Data writes stall on waitrequest while the FIFO is full.
  wire        take     = acc & ~(wr_dat & ~fin.ready);

  wire [31:0] c1_view  = {20'h0, fifo_full, fifo_empty, busy, done_r, 5'h0, irq_en_r, lsb_first_r, 1'b0};
  wire [31:0] rd_mux   = (avs_address == {1'b0, OFS_CTRL1})   ? c1_view :
                         (avs_address == {1'b0, OFS_CTRL2})   ? {19'h0, dwidth_r, 3'h0, plen_r} :
                         (avs_address == {1'b0, OFS_TERM_LO}) ? {16'h0, term_lo_r[15:0]} :
                         (avs_address == {1'b0, OFS_TERM_HI}) ? {16'h0, term_hi_r[15:0]} :
                         (avs_address == OFS_RESULT)          ? crc_r : UNMAPPED_DATA;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_r           <= 1'b0;
      avs_readdata    <= '0;
    end else begin
      ack_r           <= take;
      if (take & avs_read) avs_readdata <= rd_mux;
    end
  end

  // Waitrequest stays high until the registered acknowledge.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) avs_waitrequest <= 1'b1;
    else       avs_waitrequest <= ~take;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lsb_first_r <= 1'b0;
      irq_en_r    <= 1'b0;
      plen_r      <= PLEN_RESET;
      dwidth_r    <= DWIDTH_RESET;
      term_lo_r   <= '0;
      term_hi_r   <= '0;
    end else begin
      if (wr_c1) begin
        lsb_first_r <= avs_writedata[C1_LSB_FIRST];
        irq_en_r    <= avs_writedata[C1_IRQ_EN];
      end
      if (wr_c2) begin
        plen_r   <= avs_writedata[C2_PLEN_LSB +: FIELD_W];
        dwidth_r <= avs_writedata[C2_DWIDTH_LSB +: FIELD_W];
      end
      if (wr_lo) term_lo_r <= merge(term_lo_r, avs_writedata, avs_byteenable);
      if (wr_hi) term_hi_r <= merge(term_hi_r, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r  <= PCG_IDLE;
      crc_r    <= '0;
      shreg_r  <= '0;
      bitcnt_r <= '0;
      done_r   <= 1'b0;
    end else begin
      if (done_set)   done_r <= 1'b1;
      else if (start) done_r <= 1'b0;
      if (wr_res & ~busy) crc_r <= avs_writedata;
      case (state_r)
        PCG_IDLE: begin
          if (start & fout.valid) state_r <= PCG_LOAD;
        end
        PCG_LOAD: begin
          shreg_r  <= fout.data;
          bitcnt_r <= '0;
          state_r  <= PCG_SHIFT;
        end
        PCG_SHIFT: begin
          crc_r    <= crc_nxt;
          bitcnt_r <= bitcnt_r + 5'h01;
          if (last_bit) state_r <= fout.valid ? PCG_LOAD : PCG_IDLE;
        end
        default: state_r <= PCG_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) crc_irq <= 1'b0;
    else       crc_irq <= done_r & irq_en_r;
  end

  property p_tap0;
    @(posedge core_clk) disable iff (reset) taps[0];
  endproperty
  a_tap0: assert property (p_tap0) else $error("zero term tap missing");

  property p_shift_eq;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_SHIFT) |=> (crc_r == ($past(crc_nxt) & $past(len_mask)));
  endproperty
  a_shift_eq: assert property (p_shift_eq) else $error("engine step wrong");

  property p_len_bound;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_SHIFT) |=> ((crc_r & ~$past(len_mask)) == 32'h0);
  endproperty
  a_len_bound: assert property (p_len_bound) else $error("engine wider than length");

  property p_plen_wr;
    @(posedge core_clk) disable iff (reset)
      wr_c2 |=> (plen_r == $past(avs_writedata[4:0]));
  endproperty
  a_plen_wr: assert property (p_plen_wr) else $error("length field not written");

  property p_clear_tap;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_SHIFT && !fb) |=> (crc_r == ($past(crc_r) << 1 & $past(len_mask)));
  endproperty
  a_clear_tap: assert property (p_clear_tap) else $error("no feedback yet bits altered");

  property p_top_fb;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_SHIFT && fb) |=> crc_r[0];
  endproperty
  a_top_fb: assert property (p_top_fb) else $error("feedback not applied at bit zero");

  property p_word_len;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_LOAD) |=> (state_r == PCG_SHIFT) [*1] ##0 (bitcnt_r == 5'h00);
  endproperty
  a_word_len: assert property (p_word_len) else $error("word did not start at bit zero");

  property p_irq;
    @(posedge core_clk) disable iff (reset)
      (done_r && irq_en_r) |=> crc_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_dir;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_SHIFT && lsb_first_r && bitcnt_r == 5'h00) |-> (in_bit == shreg_r[0]);
  endproperty
  a_dir: assert property (p_dir) else $error("shift direction wrong");

  property p_tap_step;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_SHIFT && fb) |=> (crc_r == ((($past(crc_r) << 1) ^ $past(taps)) & $past(len_mask)));
  endproperty
  a_tap_step: assert property (p_tap_step) else $error("set term did not tap the engine");

  property p_len_mask;
    @(posedge core_clk) disable iff (reset)
      ((len_mask >> plen_r) == 32'h0000_0001);
  endproperty
  a_len_mask: assert property (p_len_mask) else $error("engine width is not length field plus one");

  property p_top32;
    @(posedge core_clk) disable iff (reset)
      (plen_r == 5'h1F) |-> (msb_sel == 32'h8000_0000);
  endproperty
  a_top32: assert property (p_top32) else $error("implicit top term not at bit 31");

  property p_dir_msb;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_SHIFT && !lsb_first_r && bitcnt_r == 5'h00) |-> (in_bit == shreg_r[dwidth_r]);
  endproperty
  a_dir_msb: assert property (p_dir_msb) else $error("msb first did not start at top bit");

  property p_word_end;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_SHIFT && last_bit && !fout.valid) |=> (state_r == PCG_IDLE && done_r);
  endproperty
  a_word_end: assert property (p_word_end) else $error("last word did not finish");

  property p_load_nonempty;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_LOAD) |-> fout.valid;
  endproperty
  a_load_nonempty: assert property (p_load_nonempty) else $error("load from empty fifo");

  property p_push_done;
    @(posedge core_clk) disable iff (reset)
      fin.valid |-> (avs_write && !avs_waitrequest);
  endproperty
  a_push_done: assert property (p_push_done) else $error("fifo push outside a completed write");

  property p_done_hold;
    @(posedge core_clk) disable iff (reset)
      (done_r && !start) |=> done_r;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag lost without start");

  property p_load_keep;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_LOAD) |=> $stable(crc_r);
  endproperty
  a_load_keep: assert property (p_load_keep) else $error("engine moved during load");

  property p_load_data;
    @(posedge core_clk) disable iff (reset)
      (state_r == PCG_LOAD) |=> (shreg_r == $past(fout.data));
  endproperty
  a_load_data: assert property (p_load_data) else $error("loaded word differs from fifo head");
endmodule : pcg_crc_top

// File: tb_pcg_crc_top.sv
`timescale 1ns/1ps
module tb_pcg_crc_top;
  import pcg_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  reset = 1'b1;
  logic [BUS_ADDR_W-1:0] avs_address = '0;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = '0;
  logic [3:0]            avs_byteenable = 4'hF;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic                  crc_irq;
  int                    fails = 0;
  int                    samples_checked = 0;
  logic [63:0]           notes[$];
  logic [63:0]           mon_note;
  logic [31:0]           rdv;

  pcg_crc_top u_pcg_crc_top (
    .core_clk        (core_clk),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .crc_irq         (crc_irq)
  );

  always #2.5 core_clk = ~core_clk;

  task automatic report_and_stop;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // A read notes its expectation with a mask; a zero mask marks a polling read that is not judged.
  task automatic bus(input logic wr, input logic [BUS_ADDR_W-1:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    if (!wr) begin
      notes.push_back({m, d & m});
    end
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 500);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 500) begin
      fails++;
      report_and_stop();
    end
  endtask : bus

  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      mon_note = notes.pop_front();
      if (mon_note[63:32] != 32'h0) begin
        cmp(avs_readdata & mon_note[63:32], mon_note[31:0]);
      end
    end
  end

  // Galois engine: input bit against the top stage, bit zero always tapped, taps above the order dropped.
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w, input int n, input int dw,
                                           input logic [31:0] t, input logic lsb);
    logic        fb;
    logic [31:0] mk;
    mk = (n == 32) ? 32'hFFFF_FFFF : (32'h1 << n) - 32'h1;
    for (int i = 0; i <= dw; i++) begin
      fb = w[lsb ? i : dw - i] ^ c[n-1];
      c = (c << 1) & mk;
      if (fb) begin
        c = c ^ ((t | 32'h1) & mk);
      end
    end
    return c;
  endfunction : crc_step

  task automatic run(input logic [4:0] pl, input logic [4:0] dw, input logic [31:0] t, input logic lsb,
                     input logic ie, input int nw);
    logic [31:0] c;
    logic [31:0] w;
    logic [31:0] pm;
    int          k;
    pm = (pl == 5'h1F) ? 32'hFFFF_FFFF : (32'h1 << (pl + 1)) - 32'h1;
    c = $urandom & pm;
    bus(1'b1, OFS_CTRL2, {19'h0, dw, 3'h0, pl}, '0);
    bus(1'b1, OFS_TERM_LO, {16'h0, t[15:0]}, '0);
    bus(1'b1, OFS_TERM_HI, {16'h0, t[31:16]}, '0);
    bus(1'b1, OFS_RESULT, c, '0);
    for (k = 0; k < nw; k++) begin
      w = $urandom;
      bus(1'b1, OFS_DATA, w, '0);
      c = crc_step(c, w, pl + 1, dw, t, lsb);
    end
    if (nw == FIFO_DEPTH) begin
      bus(1'b0, OFS_CTRL1, 32'h800, 32'hC00);
    end
    bus(1'b1, OFS_CTRL1, {29'h0, ie, lsb, 1'b1}, '0);
    k = 0;
    do begin
      bus(1'b0, OFS_CTRL1, '0, '0);
      k++;
    end while (rdv[C1_DONE] !== 1'b1 && k < 300);
    bus(1'b0, OFS_CTRL1, 32'h500, 32'hF00);
    cmp({31'h0, crc_irq}, {31'h0, ie});
    bus(1'b0, OFS_RESULT, c, pm);
  endtask : run

  initial begin
    #(5 * 40000);
    fails++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'hC4E8));
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    bus(1'b0, OFS_CTRL2, 32'h070F, 32'h1F1F);
    bus(1'b0, OFS_CTRL1, 32'h400, 32'hF00);
    bus(1'b0, 5'h18, 32'h0, 32'hFFFF_FFFF);
    bus(1'b1, OFS_TERM_LO, 32'h0000_1234, '0);
    avs_byteenable <= 4'h2;
    bus(1'b1, OFS_TERM_LO, 32'h0000_ABCD, '0);
    avs_byteenable <= 4'hF;
    bus(1'b0, OFS_TERM_LO, 32'h0000_AB34, 32'h0000_FFFF);
    run(5'h0F, 5'd7, 32'h0000_1020, 1'b0, 1'b0, 3);
    run(5'h1F, 5'd31, 32'h04C1_1DB6, 1'b1, 1'b1, FIFO_DEPTH);
    run(5'h04, 5'd15, 32'hFFFF_0005, 1'b0, 1'b1, 2);
    run(5'h1F, 5'd0, 32'h8000_0000, 1'b1, 1'b0, 4);
    report_and_stop();
  end
endmodule : tb_pcg_crc_top
